// ===== hw/spi_fram_params.svh
// Purpose: Constants of the protected serial memory command block
// Assumes: Byte addresses of a 512K x 8 array, 19 address bits
// Notes:   Included by the design file only
`ifndef SPI_FRAM_PARAMS_SVH
`define SPI_FRAM_PARAMS_SVH

// Opcodes
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLEAR    8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_MEM_WRITE      8'h02
`define OP_MEM_READ       8'h03

// Status register field positions
`define ST_WEL_BIT        1
`define ST_BP_LO_BIT      2
`define ST_BP_HI_BIT      3
`define ST_PROTECT_PIN_ENABLE_BIT       7
`define ST_FIXED_ONE_BIT  6

// Reset values
`define WEL_RESET         1'b0
`define PINS_RESET        4'h5

// Protected range bases
`define PROT_QTR_BASE     19'h60000
`define PROT_HALF_BASE    19'h40000
`define ADDR_LAST         19'h7FFFF

// Index of the last address byte after read or write opcode
`define ADDR_BYTES_LAST   2'h2

`endif

// ===== hw/spi_fram_pkg.sv
// Purpose: Types shared by the serial memory command block
// Assumes: Constants come from spi_fram_params.svh
// Notes:   Address width fixed at 19 bits
package spi_fram_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_WRDATA,
      ST_RDDATA,
      ST_STATUS_RD,
      ST_STATUS_WR,
      ST_IGNORE
   } cmdState_t;

   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  data;
   } wrReq_t;

   typedef struct packed {
      logic       protect_pin_enable;
      logic [1:0] bp;
   } nvStatus_t;

endpackage

// ===== hw/spi_fram_ctrl.sv
// Purpose: SPI slave command logic with write protection
// Assumes: Pins are asynchronous, sampled on clock (125 MHz)
// Notes:   Array lives outside; writes go through a small FIFO
//
// Function
// - Latch-clear opcode clears the write-enable latch, refusing later writes.
// - Status bits 0, 4, 5 read zero, bit 6 reads one, all fixed.
// - Write-enable latch is status bit 1, zero after reset.
// - Status write data never loads the latch; only the opcodes change it.
// - Block-protect bits select none, upper quarter, upper half or all.
// - Block-protect bits are retained across power cycles.
// - Protect-pin enable low makes the write-protect pin ignored.
// - Status write refused if latch clear, or if pin enable set and pin low.
// - Array write needs latch set and address outside protected range.
// - Status-read opcode shifts out the current status byte.
// - Status write loads pin enable and block bits, clears latch.
// - Three address bytes follow; low 19 bits used, top five dropped.
// - Burst write stores successive bytes, wrapping from top to zero.
// - Each data byte is eight clocks, most significant bit first.
// - Burst write hitting protected address stops and drops later bytes.
// - Each byte commits after its eighth clock; partial bytes dropped.
// - Chip select rising ends a write.
// - Read data shifts out after address, successive bytes, wrapping.
// - Serial input ignored while read data shifts out.
// - Chip select rising ends a read and releases the output.
// - Latch-set opcode sets latch; frame end clears after write commands.
// - Unknown opcode: ignore input until next frame, output released.
// - Clock level at select picks mode 0 or 3; rise in, fall out.
`timescale 1ns/100ps
`include "spi_fram_params.svh"

module spi_wr_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0]      wrPtr_q, rdPtr_q;
   logic             full, empty;

   assign full     = (wrPtr_q[PW] != rdPtr_q[PW]) &&
                     (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]);
   assign empty    = (wrPtr_q == rdPtr_q);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = store[rdPtr_q[PW-1:0]];

   always_ff @(posedge clock) begin
      if (inValid && !full) begin
         store[wrPtr_q[PW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

module spi_fram_ctrl
   import spi_fram_pkg::*;
#(
   parameter int ADDR_W     = 19,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Serial pins
   input  wire logic              sclkPin,
   input  wire logic              csPinN,
   input  wire logic              mosiPin,
   input  wire logic              wpPinN,
   output logic                   misoOut,
   output logic                   misoOe,
   // Retained protection bits
   input  wire nvStatus_t         nvStatusIn,
   output nvStatus_t              nvStatusOut,
   // Array write port
   output logic                   memWrValid,
   input  wire logic              memWrReady,
   output wrReq_t                 memWrReq,
   // Array read port, data one cycle after request
   output logic                   memRdReq,
   output logic      [ADDR_W-1:0] memRdAddr,
   input  wire logic [7:0]        memRdData,
   // Status
   output logic      [7:0]        statusOut,
   output logic                   dropOut
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   logic [3:0]       sync1_q;
   logic [3:0]       sync2_q;
   logic             sclkPrev_q;
   logic             csPrev_q;
   logic             sclkS, csS, mosiS, wpS;
   logic             sclkRise, sclkFall, csFall, csRise;

   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_q    <= `PINS_RESET;
         sync2_q    <= `PINS_RESET;
         sclkPrev_q <= 1'b0;
         csPrev_q   <= 1'b1;
      end else begin
         sync1_q    <= {sclkPin, csPinN, mosiPin, wpPinN};
         sync2_q    <= sync1_q;
         sclkPrev_q <= sync2_q[3];
         csPrev_q   <= sync2_q[2];
      end
   end

   assign sclkS    = sync2_q[3];
   assign csS      = sync2_q[2];
   assign mosiS    = sync2_q[1];
   assign wpS      = sync2_q[0];
   assign sclkRise = sclkS && !sclkPrev_q && !csS;
   assign sclkFall = !sclkS && sclkPrev_q && !csS;
   assign csFall   = !csS && csPrev_q;
   assign csRise   = csS && !csPrev_q;

   ////////////////////////////////////////////////////////////////////
   // Functions
   function automatic logic isProtected(input logic [ADDR_W-1:0] a,
                                        input logic [1:0]        bp);
      case (bp)
         2'h0:    isProtected = 1'b0;
         2'h1:    isProtected = (a >= `PROT_QTR_BASE);
         2'h2:    isProtected = (a >= `PROT_HALF_BASE);
         2'h3:    isProtected = 1'b1;
         default: isProtected = 1'b1;
      endcase
   endfunction

   function automatic cmdState_t decodeOp(input logic [7:0] op);
      case (op)
         `OP_LATCH_SET, `OP_LATCH_CLEAR: decodeOp = ST_IGNORE;
         `OP_STATUS_READ:  decodeOp = ST_STATUS_RD;
         `OP_STATUS_WRITE: decodeOp = ST_STATUS_WR;
         `OP_MEM_WRITE:    decodeOp = ST_ADDR;
         `OP_MEM_READ:     decodeOp = ST_ADDR;
         default:          decodeOp = ST_IGNORE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Receive shifting and command sequencing
   cmdState_t        state_q;
   logic [2:0]       bitCnt_q;
   logic [1:0]       addrCnt_q;
   logic [7:0]       rxShift_q;
   logic [15:0]      addrHi_q;
   logic [ADDR_W-1:0] addr_q;
   logic             readSel_q, modeHigh_q, sawRise_q;
   logic             wel_q, clrPend_q;
   nvStatus_t        nv_q;
   logic [7:0]       rxByte;
   logic             byteDone;
   logic [ADDR_W-1:0] newAddr;
   logic             wrAllowed, fifoInReady, pushValid;
   wrReq_t           pushReq;
   logic [7:0]       statusByte;

   assign rxByte    = {rxShift_q[6:0], mosiS};
   assign byteDone  = sclkRise && (bitCnt_q == 3'h7);
   assign newAddr   = ADDR_W'({addrHi_q, rxByte});
   assign wrAllowed = wel_q && !isProtected(addr_q, nv_q.bp);
   assign pushValid = byteDone && (state_q == ST_WRDATA) && wrAllowed;
   assign pushReq   = '{addr: addr_q, data: rxByte};

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q    <= ST_IDLE;
         bitCnt_q   <= 3'h0;
         addrCnt_q  <= 2'h0;
         rxShift_q  <= 8'h00;
         addrHi_q   <= 16'h0000;
         addr_q     <= '0;
         readSel_q  <= 1'b0;
         modeHigh_q <= 1'b0;
         sawRise_q  <= 1'b0;
      end else if (csRise) begin
         state_q <= ST_IDLE;
      end else if (csFall) begin
         state_q    <= ST_OPCODE;
         bitCnt_q   <= 3'h0;
         addrCnt_q  <= 2'h0;
         modeHigh_q <= sclkS;
         sawRise_q  <= 1'b0;
      end else if (sclkRise && state_q != ST_IDLE) begin
         sawRise_q <= 1'b1;
         bitCnt_q  <= bitCnt_q + 3'h1;
         if (state_q != ST_RDDATA && state_q != ST_IGNORE) begin
            rxShift_q <= rxByte;
         end
         if (byteDone) begin
            case (state_q)
               ST_OPCODE: begin
                  state_q   <= decodeOp(rxByte);
                  readSel_q <= (rxByte == `OP_MEM_READ);
               end
               ST_ADDR: begin
                  addrHi_q  <= {addrHi_q[7:0], rxByte};
                  addrCnt_q <= addrCnt_q + 2'h1;
                  if (addrCnt_q == `ADDR_BYTES_LAST) begin
                     addr_q  <= readSel_q ? newAddr + 1'b1 : newAddr;
                     state_q <= readSel_q ? ST_RDDATA : ST_WRDATA;
                  end
               end
               ST_WRDATA: begin
                  if (wrAllowed) begin
                     addr_q <= addr_q + 1'b1;
                  end else begin
                     state_q <= ST_IGNORE;
                  end
               end
               ST_RDDATA:    addr_q  <= addr_q + 1'b1;
               ST_STATUS_WR: state_q <= ST_IGNORE;
               ST_STATUS_RD: state_q <= ST_STATUS_RD;
               ST_IGNORE:    state_q <= ST_IGNORE;
               default:      state_q <= ST_IGNORE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write-enable latch
   always_ff @(posedge clock) begin
      if (rst) begin
         wel_q     <= `WEL_RESET;
         clrPend_q <= 1'b0;
      end else if (csRise) begin
         if (clrPend_q) begin
            wel_q <= 1'b0;
         end
         clrPend_q <= 1'b0;
      end else if (byteDone && state_q == ST_OPCODE) begin
         case (rxByte)
            `OP_LATCH_SET:  wel_q <= 1'b1;
            `OP_LATCH_CLEAR: begin
               wel_q     <= 1'b0;
               clrPend_q <= 1'b1;
            end
            `OP_STATUS_WRITE, `OP_MEM_WRITE: clrPend_q <= 1'b1;
            default: clrPend_q <= clrPend_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Retained protection bits and status byte
   always_ff @(posedge clock) begin
      if (rst) begin
         nv_q <= nvStatusIn;
      end else if (byteDone && state_q == ST_STATUS_WR &&
                   wel_q && !(nv_q.protect_pin_enable && !wpS)) begin
         nv_q.protect_pin_enable <= rxByte[`ST_PROTECT_PIN_ENABLE_BIT];
         nv_q.bp   <= {rxByte[`ST_BP_HI_BIT], rxByte[`ST_BP_LO_BIT]};
      end
   end

   always_comb begin
      statusByte                    = 8'h00;
      statusByte[`ST_FIXED_ONE_BIT] = 1'b1;
      statusByte[`ST_PROTECT_PIN_ENABLE_BIT]      = nv_q.protect_pin_enable;
      statusByte[`ST_BP_HI_BIT]     = nv_q.bp[1];
      statusByte[`ST_BP_LO_BIT]     = nv_q.bp[0];
      statusByte[`ST_WEL_BIT]       = wel_q;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         statusOut   <= 8'h40;
         nvStatusOut <= '0;
      end else begin
         statusOut   <= statusByte;
         nvStatusOut <= nv_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write path through FIFO to the array
   logic   fifoOutValid, fifoOutReady;
   wrReq_t fifoOut;

   spi_wr_fifo #(
      .WIDTH ($bits(wrReq_t)),
      .DEPTH (FIFO_DEPTH)
   ) wrFifo (
      .clock    (clock),
      .rst      (rst),
      .inValid  (pushValid),
      .inReady  (fifoInReady),
      .inData   (pushReq),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOut)
   );

   assign fifoOutReady = !memWrValid || memWrReady;

   always_ff @(posedge clock) begin
      if (rst) begin
         memWrValid <= 1'b0;
         memWrReq   <= '0;
      end else if (fifoOutReady) begin
         memWrValid <= fifoOutValid;
         memWrReq   <= fifoOut;
      end
   end

   // Overflow marker, held until the next frame starts
   always_ff @(posedge clock) begin
      if (rst || csFall) begin
         dropOut <= 1'b0;
      end else if (pushValid && !fifoInReady) begin
         dropOut <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read requests and serial output
   logic       rdPend_q, txLoaded_q;
   logic [7:0] txShift_q;
   logic       rdIssue;

   assign rdIssue = byteDone && ((state_q == ST_ADDR && readSel_q &&
                    addrCnt_q == `ADDR_BYTES_LAST) ||
                    state_q == ST_RDDATA);

   always_ff @(posedge clock) begin
      if (rst) begin
         memRdReq  <= 1'b0;
         memRdAddr <= '0;
         rdPend_q  <= 1'b0;
      end else begin
         memRdReq <= rdIssue && !csRise;
         rdPend_q <= memRdReq;
         if (rdIssue) begin
            memRdAddr <= (state_q == ST_ADDR) ? newAddr : addr_q;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         txLoaded_q <= 1'b0;
         txShift_q  <= 8'h00;
         misoOut    <= 1'b0;
         misoOe     <= 1'b0;
      end else if (csRise || csFall) begin
         txLoaded_q <= 1'b0;
         misoOe     <= 1'b0;
      end else if (byteDone && ((state_q == ST_OPCODE &&
                   rxByte == `OP_STATUS_READ) ||
                   state_q == ST_STATUS_RD)) begin
         txShift_q  <= statusByte;
         txLoaded_q <= 1'b1;
      end else if (rdPend_q && state_q == ST_RDDATA) begin
         txShift_q  <= memRdData;
         txLoaded_q <= 1'b1;
      end else if (sclkFall && txLoaded_q &&
                   !(modeHigh_q && !sawRise_q)) begin
         misoOut   <= txShift_q[7];
         misoOe    <= 1'b1;
         txShift_q <= {txShift_q[6:0], 1'b0};
      end
   end

endmodule

// ===== dv/spi_fram_ctrl_assertions.sv
// Purpose: Port checks on the serial memory command block
// Assumes: Pins pass two sync flops, statusOut lags one clock
// Notes:   Bound to every instance of spi_fram_ctrl
`timescale 1ns/100ps
module spi_fram_ctrl_checker
   import spi_fram_pkg::*;
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Observed ports
   input wire logic       csPinN,
   input wire logic       misoOe,
   input wire nvStatus_t  nvStatusOut,
   input wire logic       memWrValid,
   input wire logic       memWrReady,
   input wire wrReq_t     memWrReq,
   input wire logic       memRdReq,
   input wire logic [7:0] statusOut,
   input wire logic       dropOut
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_FIXED_BITS:
      assert property (statusOut[6:4] == 3'h4 && !statusOut[0])
      else $error("fixed status bits wrong");
   AST_NV_STABLE:
      assert property (csPinN [*4] |-> $stable(nvStatusOut))
      else $error("protection bits moved outside a frame");
   AST_MISO_RELEASE:
      assert property (csPinN [*5] |-> !misoOe)
      else $error("output driven while deselected");
   AST_WR_HOLD:
      assert property (memWrValid && !memWrReady
         |=> memWrValid && $stable(memWrReq))
      else $error("write request changed while stalled");
   AST_RD_PULSE:
      assert property (memRdReq |=> !memRdReq)
      else $error("read request longer than one cycle");
   AST_WR_NEEDS_WEL:
      assert property ($rose(memWrValid)
         |-> statusOut[1] || $past(statusOut[1]))
      else $error("array write without write enable");
   AST_WEL_IN_FRAME:
      assert property ($rose(statusOut[1]) |-> !$past(csPinN, 4))
      else $error("write enable set outside a frame");
   AST_OE_IN_FRAME:
      assert property ($rose(misoOe) |-> !csPinN && !$past(csPinN, 3))
      else $error("output enabled outside a frame");

   COV_WRITE: cover property (memWrValid && memWrReady);
   COV_READ:  cover property (memRdReq);
   COV_DROP:  cover property ($rose(dropOut));
endmodule

bind spi_fram_ctrl spi_fram_ctrl_checker spi_fram_ctrl_checker_inst (
   .clock(clock), .rst(rst), .csPinN(csPinN), .misoOe(misoOe),
   .nvStatusOut(nvStatusOut), .memWrValid(memWrValid),
   .memWrReady(memWrReady), .memWrReq(memWrReq), .memRdReq(memRdReq),
   .statusOut(statusOut), .dropOut(dropOut)
);

// ===== dv/spi_master_model.sv
// Purpose: Serial bus master driving the memory block
// Assumes: 80 ns link period, mode from idle clock level
// Notes:   Data line inverted when released
`timescale 1ns/100ps
module spi_master_model (
   // Serial pins toward the device
   output logic      sclkPin,
   output logic      csPinN,
   output logic      mosiPin,
   input  wire logic misoOut,
   input  wire logic misoOe
);
   initial begin
      sclkPin = 1'b0;
      csPinN  = 1'b1;
      mosiPin = 1'b0;
   end

   // One whole frame; clock still outside it
   task automatic frame(input logic [95:0] tx, input int nBits,
         input bit mode3, output logic [95:0] rx, output bit oeSeen);
      rx = '0;
      oeSeen = 1'b0;
      sclkPin = mode3;
      #100 csPinN = 1'b0;
      #100;
      for (int i = 0; i < nBits; i++) begin
         sclkPin = 1'b0;
         mosiPin = tx[95 - i];
         #40 sclkPin = 1'b1;
         rx[95 - i] = misoOe ? misoOut : !misoOut;
         oeSeen = oeSeen | misoOe;
         #40;
      end
      sclkPin = mode3;
      #40 csPinN = 1'b1;
      mosiPin = ~mosiPin;
      #200;
   endtask
endmodule

// ===== dv/tb_spi_fram_ctrl.sv
// Purpose: Self-checking bench of the serial memory block
// Assumes: Array answers reads one cycle after the request
// Notes:   Reset and latch checks, status write table, then hand-written cases
`timescale 1ns/100ps
module tb_spi_fram_ctrl
   import spi_fram_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst   = 1'b1;
   logic        sclkPin, csPinN, mosiPin, misoOut, misoOe;
   logic        wpPinN, memWrValid, memWrReady, memRdReq, dropOut;
   logic [18:0] memRdAddr;
   logic [7:0]  memRdData, statusOut;
   nvStatus_t   nvIn, nvStatusOut;
   wrReq_t      memWrReq;
   wrReq_t      wrLog[$];
   logic [95:0] rxv;
   bit          oeSeen;
   int          error_cnt  = 0;
   int          n_compared = 0;
   typedef struct packed {
      logic latch_set_cmd; logic wp; logic [7:0] data; logic [3:0] nb;
      logic [7:0] exp;
   } row_t;
   row_t rows[8] = '{
      '{1'b1, 1'b1, 8'hFF, 4'h8, 8'hCC}, '{1'b1, 1'b0, 8'h00, 4'h8, 8'hCC},
      '{1'b1, 1'b1, 8'h04, 4'h8, 8'h44}, '{1'b1, 1'b0, 8'h08, 4'h8, 8'h48},
      '{1'b1, 1'b0, 8'h80, 4'h8, 8'hC0}, '{1'b1, 1'b1, 8'h00, 4'h8, 8'h40},
      '{1'b0, 1'b1, 8'h0C, 4'h8, 8'h40}, '{1'b1, 1'b1, 8'h0C, 4'h5, 8'h40}};

   always #4 clock = ~clock;

   spi_fram_ctrl spi_fram_ctrl_inst (
      .clock(clock), .rst(rst), .sclkPin(sclkPin), .csPinN(csPinN),
      .mosiPin(mosiPin), .wpPinN(wpPinN), .misoOut(misoOut),
      .misoOe(misoOe), .nvStatusIn(nvIn), .nvStatusOut(nvStatusOut),
      .memWrValid(memWrValid), .memWrReady(memWrReady),
      .memWrReq(memWrReq), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
      .memRdData(memRdData), .statusOut(statusOut), .dropOut(dropOut));
   spi_master_model spi_master_model_inst (
      .sclkPin(sclkPin), .csPinN(csPinN), .mosiPin(mosiPin),
      .misoOut(misoOut), .misoOe(misoOe));

   ////////////////////////////////////////////////////////////////////
   // Array model
   always @(posedge clock) begin
      if (memWrValid && memWrReady)
         wrLog.push_back(memWrReq);
      if (memRdReq)
         memRdData <= pat(memRdAddr);
   end

   function automatic logic [7:0] pat(input logic [18:0] a);
      return a[7:0] ^ {a[18:15], 4'hC};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic sf(input logic [95:0] tx, input int nBits,
         input bit m3 = 1'b0);
      @(posedge clock) #1;
      spi_master_model_inst.frame(tx, nBits, m3, rxv, oeSeen);
   endtask
   task automatic rds();
      sf({8'h05, 88'h0}, 16);
   endtask
   task automatic setIn(input logic wp, input logic rdy);
      @(posedge clock);
      #1 wpPinN = wp;
      memWrReady = rdy;
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #500000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      wpPinN = 1'b1;
      memWrReady = 1'b1;
      memRdData = 8'h00;
      nvIn = 3'b010;
      repeat (10) @(posedge clock);
      #1 rst = 1'b0;
      repeat (4) @(posedge clock) #1;
      check("reset status", statusOut, 8'h48);
      check("nv out", nvStatusOut, 3'b010);
      check("reset oe", misoOe, 1'b0);
      sf({8'h06, 88'h0}, 8);
      rds();
      check("latch set", rxv[87:80], 8'h4A);
      sf({8'h04, 88'h0}, 8);
      rds();
      check("latch clear", rxv[87:80], 8'h48);
      foreach (rows[i]) begin
         setIn(rows[i].wp, 1'b1);
         if (rows[i].latch_set_cmd)
            sf({8'h06, 88'h0}, 8);
         sf({8'h01, rows[i].data, 80'h0}, 8 + rows[i].nb);
         rds();
         check("status read", rxv[87:80], rows[i].exp);
         check("statusOut", statusOut, rows[i].exp);
      end
      // Burst across the top address, partial tail
      sf({8'h06, 88'h0}, 8);
      sf({8'h02, 24'hE7FFFF, 24'hA1B2C3, 40'h0}, 59);
      repeat (20) @(posedge clock);
      check("write count", wrLog.size(), 3);
      check("write 0", wrLog[0], {19'h7FFFF, 8'hA1});
      check("write 1", wrLog[1], {19'h00000, 8'hB2});
      check("write 2", wrLog[2], {19'h00001, 8'hC3});
      check("latch after write", statusOut[1], 1'b0);
      sf({8'h02, 24'h000010, 8'h55, 56'h0}, 40);
      // Upper quarter protected, burst runs into it
      sf({8'h06, 88'h0}, 8);
      sf({8'h01, 8'h04, 80'h0}, 16);
      sf({8'h06, 88'h0}, 8);
      sf({8'h02, 24'h05FFFE, 24'h112233, 40'h0}, 56);
      repeat (20) @(posedge clock);
      check("protected count", wrLog.size(), 5);
      check("last below", wrLog[4], {19'h5FFFF, 8'h22});
      // Read wrap in mode 3 with noisy input
      sf({8'h03, 24'hE7FFFF, 8'hFF, 8'h00, 48'h0}, 48, 1'b1);
      check("read 0", rxv[63:56], pat(19'h7FFFF));
      check("read 1", rxv[55:48], pat(19'h00000));
      check("read oe", misoOe, 1'b0);
      sf({8'hA5, 88'h0}, 24);
      check("unknown oe", oeSeen, 1'b0);
      // Fill the buffer while the array stalls
      setIn(1'b1, 1'b0);
      sf({8'h06, 88'h0}, 8);
      sf({8'h02, 24'h000100, 48'h101112131415, 16'h0}, 80);
      check("drop", dropOut, 1'b1);
      check("stalled", wrLog.size(), 5);
      setIn(1'b1, 1'b1);
      repeat (20) @(posedge clock);
      check("drained", wrLog.size(), 10);
      check("fifo head", wrLog[5], {19'h00100, 8'h10});
      give_verdict();
   end
endmodule
